// [hdl/pio_pkg.sv]
package pio_pkg;

   // ==========================================================
   // Line count and defined-line map
   // ==========================================================
   localparam int          LINE_COUNT    = 32;
   localparam logic [31:0] DEFINED_LINES = 32'hFFFF_FFFF;

   // ==========================================================
   // Values after reset
   // ==========================================================
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
   localparam logic [31:0] SYNC_MASK_RST   = 32'h0000_0000;
   localparam logic [31:0] OPEN_DRAIN_RST  = 32'h0000_0000;
   localparam logic [31:0] FILTER_RST      = 32'h0000_0000;
   localparam logic [31:0] IRQ_MASK_RST    = 32'h0000_0000;
   localparam logic [31:0] IRQ_STATUS_RST  = 32'h0000_0000;
   localparam logic [31:0] OUT_DATA_RST    = 32'h0000_0000;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int          SYNC_STAGES     = 2;

endpackage

// [hdl/sync_2ff.sv]
`timescale 1ns/1ns

// ==========================================================
// Two-flop level synchroniser
// ==========================================================
module sync_2ff
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         q_out  <= '0;
      end
      else
      begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end

endmodule

// [hdl/line_filter.sv]
`timescale 1ns/1ns

// ==========================================================
// Per-line half-cycle glitch filter
// ==========================================================
// Samples the pin on both clock edges; a level is accepted only
// once a falling-edge and the following rising-edge sample agree,
// so a pulse shorter than half a period is never seen twice.
module line_filter
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic pin,
   input  wire logic filt_en,
   input  wire logic run,
   output logic      raw_level,
   output logic      level
);

   logic rise_meta_r;
   logic fall_meta_r;
   logic fall_r;
   logic fall_prev_r;

   // Rising-edge synchroniser, unfiltered path
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rise_meta_r <= 1'b0;
         raw_level   <= 1'b0;
      end
      else
      begin
         rise_meta_r <= pin;
         raw_level   <= rise_meta_r;
      end
   end

   // Falling-edge synchroniser for the half-cycle sample
   always_ff @(negedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fall_meta_r <= 1'b0;
         fall_r      <= 1'b0;
      end
      else
      begin
         fall_meta_r <= pin;
         fall_r      <= fall_meta_r;
      end
   end

   // Falling sample from half a cycle before the rising one now in
   // raw_level; no first-stage flop feeds the compare
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         fall_prev_r <= 1'b0;
      else
         fall_prev_r <= fall_r;
   end

   // Filtered level only advances while the block clock runs
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         level <= 1'b0;
      else if (!run)                                         // RL13
         level <= level;
      else if (!filt_en)
         level <= raw_level;
      else if (raw_level == fall_prev_r)                     // RL9 RL10
         level <= raw_level;
   end

endmodule

// [hdl/pio_line_ctrl.sv]
`timescale 1ns/1ns

// Contract
// RL1: Direct output data write changes only lines whose sync mask is set.
// RL2: Mask enable writes set mask bits, disable writes clear; zeros no effect.
// RL3: Sync write mask resets to all zeros.
// RL4: Open-drain lines are only pulled low, released instead of driven high.
// RL5: Open-drain enable/disable set/clear status; applies to controller or peripheral.
// RL6: Open-drain status resets to all zeros.
// RL7: Pin level status returns sampled level of every line, any configuration.
// RL8: With block clock gated off, pin level status holds last sampled levels.
// RL9: Filter rejects pulses under half a cycle, accepts a full cycle; code accepts only pulses spanning a falling edge and the next rising edge.
// RL10: Filter adds a cycle when change precedes rising edge, none for falling.
// RL11: Filter enable/disable writes set/clear filter status; set bit filters line.
// RL12: Filter affects level readback and change detection, not peripheral inputs.
// RL13: Filtering runs only while the block clock is on.
// RL14: Irq enable writes set mask bits, irq disable writes clear them.
// RL15: Change found by comparing two consecutive samples; none while clock off.
// RL16: Change detection works on every line whatever its configuration.
// RL17: Change sets status bit; irq asserted when status and mask both set.
// RL18: All lines' masked conditions ORed onto one interrupt output.
// RL19: Reading irq status returns pending bits then clears them all.
// RL20: Software must service all lines reported in one status read.
// RL21: Set/clear output writes set/clear matching output data status bits.
// RL22: Undefined line bits ignore writes and read as zero.
// RL23: Output data status reads the whole word regardless of sync mask.
// RL24: Output writes update the driven pin level on the following edge.
module pio_line_ctrl
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        clock_on,
   input  wire logic [31:0] wr_data,
   input  wire logic        set_output_data_we,
   input  wire logic        clear_output_data_we,
   input  wire logic        output_data_status_we,
   input  wire logic        sync_write_mask_enable_we,
   input  wire logic        sync_write_mask_disable_we,
   input  wire logic        open_drain_enable_we,
   input  wire logic        open_drain_disable_we,
   input  wire logic        glitch_filter_enable_we,
   input  wire logic        glitch_filter_disable_we,
   input  wire logic        change_irq_enable_we,
   input  wire logic        change_irq_disable_we,
   input  wire logic        change_irq_status_rd,
   input  wire logic [31:0] line_owned,
   input  wire logic [31:0] line_drive_en,
   input  wire logic [31:0] periph_out,
   input  wire logic [31:0] periph_oe,
   input  wire logic [31:0] pin_in,
   output logic      [31:0] pin_out,
   output logic      [31:0] pin_oe,
   output logic      [31:0] periph_in,
   output logic      [31:0] output_data_status,
   output logic      [31:0] sync_write_mask_status,
   output logic      [31:0] open_drain_status,
   output logic      [31:0] glitch_filter_status,
   output logic      [31:0] pin_level_status,
   output logic      [31:0] change_irq_mask,
   output logic      [31:0] change_irq_status,
   output logic             irq
);

   // ==========================================================
   // Internal signals
   // ==========================================================
   logic [31:0] wr_bits;
   logic [31:0] raw_level;
   logic [31:0] filt_level;
   logic [31:0] prev_level_r;
   logic [31:0] change_v;
   logic [31:0] odsr_nxt;
   logic [31:0] status_nxt;
   logic [31:0] drv_level;
   logic [31:0] drv_en;
   logic        run;

   // Undefined lines never take a written one
   assign wr_bits = wr_data & pio_pkg::DEFINED_LINES;           // RL22

   // ==========================================================
   // Clock-gate indication crosses from the power manager
   // ==========================================================
   sync_2ff #(.WIDTH(1)) u_run_sync
   (
      .clock (clock),
      .rst_b (rst_b),
      .d_in  (clock_on),
      .q_out (run)
   );

   // ==========================================================
   // Per-line filters
   // ==========================================================
   genvar gi;
   generate
      for (gi = 0; gi < pio_pkg::LINE_COUNT; gi++)
      begin : g_line
         line_filter u_filter
         (
            .clock     (clock),
            .rst_b     (rst_b),
            .pin       (pin_in[gi]),
            .filt_en   (glitch_filter_status[gi]),          // RL11
            .run       (run),
            .raw_level (raw_level[gi]),
            .level     (filt_level[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Output data and sync write mask
   // ==========================================================
   // Set then clear, then the masked direct write; one single
   // write never passes a transient value to the pins
   always_comb
   begin
      odsr_nxt = output_data_status;
      if (set_output_data_we)
         odsr_nxt = odsr_nxt | wr_bits;                         // RL21
      if (clear_output_data_we)
         odsr_nxt = odsr_nxt & ~wr_bits;                        // RL21
      if (output_data_status_we)
         odsr_nxt = (odsr_nxt & ~sync_write_mask_status)        // RL1
                  | (wr_bits & sync_write_mask_status);
   end

   // Output data register, readable whole word
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         output_data_status <= pio_pkg::OUT_DATA_RST;
      else
         output_data_status <= odsr_nxt;                        // RL23
   end

   // Mask: disable wins when both strobes hit one bit
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         sync_write_mask_status <= pio_pkg::SYNC_MASK_RST;      // RL3
      else if (sync_write_mask_enable_we || sync_write_mask_disable_we)
         sync_write_mask_status <= (sync_write_mask_status       // RL2
            | (sync_write_mask_enable_we ? wr_bits : 32'h0000_0000))
            & ~(sync_write_mask_disable_we ? wr_bits : 32'h0000_0000);
   end

   // ==========================================================
   // Open-drain and filter configuration
   // ==========================================================
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         open_drain_status <= pio_pkg::OPEN_DRAIN_RST;          // RL6
      else if (open_drain_enable_we || open_drain_disable_we)
         open_drain_status <= (open_drain_status                // RL5
            | (open_drain_enable_we ? wr_bits : 32'h0000_0000))
            & ~(open_drain_disable_we ? wr_bits : 32'h0000_0000);
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         glitch_filter_status <= pio_pkg::FILTER_RST;
      else if (glitch_filter_enable_we || glitch_filter_disable_we)
         glitch_filter_status <= (glitch_filter_status          // RL11
            | (glitch_filter_enable_we ? wr_bits : 32'h0000_0000))
            & ~(glitch_filter_disable_we ? wr_bits : 32'h0000_0000);
   end

   // ==========================================================
   // Pin drive
   // ==========================================================
   // Owner picks level and enable; open drain never drives high
   assign drv_level = (line_owned & output_data_status)
                    | (~line_owned & periph_out);
   assign drv_en    = (line_owned & line_drive_en)
                    | (~line_owned & periph_oe);

   // Registered pins: output follows the data register one edge on
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_out <= pio_pkg::ZERO_WORD;
         pin_oe  <= pio_pkg::ZERO_WORD;
      end
      else
      begin
         pin_out <= drv_level & ~open_drain_status;             // RL4
         pin_oe  <= drv_en & ~(open_drain_status & drv_level);  // RL4 RL5 RL24
      end
   end

   // Peripherals see the synchronised but unfiltered pin
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         periph_in <= pio_pkg::ZERO_WORD;
      else
         periph_in <= raw_level;                                // RL12
   end

   // ==========================================================
   // Pin level readback
   // ==========================================================
   // Frozen while the block clock is gated, as the real flops would be
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         pin_level_status <= pio_pkg::ZERO_WORD;
      else if (run)
         pin_level_status <= filt_level                         // RL7 RL12
                           & pio_pkg::DEFINED_LINES;            // RL22
   end                                                          // RL8

   // ==========================================================
   // Input change interrupt
   // ==========================================================
   // Previous sample only moves when the clock runs
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         prev_level_r <= pio_pkg::ZERO_WORD;
      else if (run)
         prev_level_r <= filt_level;                            // RL15
   end

   // Any line, any owner; no detection while gated
   assign change_v = run ? ((filt_level ^ prev_level_r)         // RL15 RL16
                           & pio_pkg::DEFINED_LINES)
                         : pio_pkg::ZERO_WORD;

   // A change in the read cycle survives the clear
   assign status_nxt = (change_irq_status_rd ? pio_pkg::ZERO_WORD // RL19
                                             : change_irq_status)
                     | change_v;                                // RL17

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         change_irq_status <= pio_pkg::IRQ_STATUS_RST;
      else
         change_irq_status <= status_nxt;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         change_irq_mask <= pio_pkg::IRQ_MASK_RST;
      else if (change_irq_enable_we || change_irq_disable_we)
         change_irq_mask <= (change_irq_mask                    // RL14
            | (change_irq_enable_we ? wr_bits : 32'h0000_0000))
            & ~(change_irq_disable_we ? wr_bits : 32'h0000_0000);
   end

   // One request line from all masked status bits
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= |(change_irq_status & change_irq_mask);        // RL17 RL18
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   sequence s_direct_write;
      output_data_status_we && !set_output_data_we
         && !clear_output_data_we;
   endsequence

   property p_masked_write;
      @(posedge clock) disable iff (!rst_b)
      s_direct_write |=> ((output_data_status
         & ~$past(sync_write_mask_status))
         == ($past(output_data_status)
         & ~$past(sync_write_mask_status)))
         && ((output_data_status & $past(sync_write_mask_status))
         == ($past(wr_bits) & $past(sync_write_mask_status)));
   endproperty
   a_masked_write: assert property (p_masked_write) // RL1
      else $error("masked write touched a masked line");

   property p_mask_set;
      @(posedge clock) disable iff (!rst_b)
      sync_write_mask_enable_we && !sync_write_mask_disable_we
      |=> ((sync_write_mask_status & $past(wr_bits))
           == $past(wr_bits))
          && ((sync_write_mask_status & ~$past(wr_bits))
           == ($past(sync_write_mask_status) & ~$past(wr_bits)));
   endproperty
   a_mask_set: assert property (p_mask_set) // RL2
      else $error("sync mask enable wrong");

   property p_open_drain_no_high;
      @(posedge clock) disable iff (!rst_b)
      ##1 ((pin_out & $past(open_drain_status)) == 32'h0000_0000);
   endproperty
   a_open_drain_no_high: assert property (p_open_drain_no_high) // RL4
      else $error("open-drain line driven high");

   property p_level_hold;
      @(posedge clock) disable iff (!rst_b)
      !run |=> $stable(pin_level_status);
   endproperty
   a_level_hold: assert property (p_level_hold) // RL8
      else $error("pin level moved while gated");

   property p_read_clear;
      @(posedge clock) disable iff (!rst_b)
      change_irq_status_rd |=> change_irq_status == $past(change_v);
   endproperty
   a_read_clear: assert property (p_read_clear) // RL19
      else $error("status not cleared by read");

   property p_change_sets;
      @(posedge clock) disable iff (!rst_b)
      (change_v != 32'h0000_0000)
      |=> ((change_irq_status & $past(change_v)) == $past(change_v));
   endproperty
   a_change_sets: assert property (p_change_sets) // RL17
      else $error("change did not set status");

   sequence s_pending;
      (change_irq_status & change_irq_mask) != 32'h0000_0000;
   endsequence

   property p_irq_out;
      @(posedge clock) disable iff (!rst_b)
      s_pending |=> irq;
   endproperty
   a_irq_out: assert property (p_irq_out) // RL18
      else $error("irq missing for pending masked line");

   property p_irq_quiet;
      @(posedge clock) disable iff (!rst_b)
      (change_irq_status & change_irq_mask) == 32'h0000_0000 |=> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) // RL17
      else $error("irq without masked pending line");

   property p_set_output;
      @(posedge clock) disable iff (!rst_b)
      set_output_data_we && !clear_output_data_we
         && !output_data_status_we
      |=> ((output_data_status & $past(wr_bits)) == $past(wr_bits));
   endproperty
   a_set_output: assert property (p_set_output) // RL21
      else $error("set output did not set bits");

   property p_no_gate_change;
      @(posedge clock) disable iff (!rst_b)
      !run && !change_irq_status_rd |=> $stable(change_irq_status);
   endproperty
   a_no_gate_change: assert property (p_no_gate_change) // RL15
      else $error("change seen while gated");

endmodule

// [dv/pin_world.sv]
`timescale 1ns/1ns

// ==========================================================
// Far side: shared pin wires, pull-up, external drivers
// ==========================================================
module pin_world
(
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] ext_en,
   input  wire logic [31:0] ext_level,
   output logic      [31:0] pin_in
);
   logic [31:0] pull_low;

   // Wired-AND with pull-up: any low driver wins, released reads high
   assign pull_low = (pin_oe & ~pin_out) | (ext_en & ~ext_level);
   assign pin_in   = ~pull_low;
endmodule

// [dv/tb.sv]
`timescale 1ns/1ns

// ==========================================================
// Bench for the per-line controller
// ==========================================================
module tb;
   localparam int S_SET = 0;
   localparam int S_CLR = 1;
   localparam int S_ODS = 2;
   localparam int S_MEN = 3;
   localparam int S_MDIS = 4;
   localparam int S_ODEN = 5;
   localparam int S_ODDIS = 6;
   localparam int S_FEN = 7;
   localparam int S_FDIS = 8;
   localparam int S_IEN = 9;
   localparam int S_IDIS = 10;
   localparam int S_RD = 11;

   logic        clock;
   logic        rst_b;
   logic        clock_on;
   logic [31:0] wr_data;
   logic [11:0] stb;
   logic [31:0] line_owned;
   logic [31:0] line_drive_en;
   logic [31:0] periph_out;
   logic [31:0] periph_oe;
   logic [31:0] ext_en;
   logic [31:0] ext_level;
   logic [31:0] pin_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic [31:0] periph_in;
   logic [31:0] ods;
   logic [31:0] mask;
   logic [31:0] odr;
   logic [31:0] filt;
   logic [31:0] pls;
   logic [31:0] imask;
   logic [31:0] istat;
   logic        irq;
   int          lows = 0;
   int          miscompares;
   int          checks_done;
   int          cycles = 0;

   pio_line_ctrl u_dut
   (
      .clock                      (clock),
      .rst_b                      (rst_b),
      .clock_on                   (clock_on),
      .wr_data                    (wr_data),
      .set_output_data_we         (stb[S_SET]),
      .clear_output_data_we       (stb[S_CLR]),
      .output_data_status_we      (stb[S_ODS]),
      .sync_write_mask_enable_we  (stb[S_MEN]),
      .sync_write_mask_disable_we (stb[S_MDIS]),
      .open_drain_enable_we       (stb[S_ODEN]),
      .open_drain_disable_we      (stb[S_ODDIS]),
      .glitch_filter_enable_we    (stb[S_FEN]),
      .glitch_filter_disable_we   (stb[S_FDIS]),
      .change_irq_enable_we       (stb[S_IEN]),
      .change_irq_disable_we      (stb[S_IDIS]),
      .change_irq_status_rd       (stb[S_RD]),
      .line_owned                 (line_owned),
      .line_drive_en              (line_drive_en),
      .periph_out                 (periph_out),
      .periph_oe                  (periph_oe),
      .pin_in                     (pin_in),
      .pin_out                    (pin_out),
      .pin_oe                     (pin_oe),
      .periph_in                  (periph_in),
      .output_data_status         (ods),
      .sync_write_mask_status     (mask),
      .open_drain_status          (odr),
      .glitch_filter_status       (filt),
      .pin_level_status           (pls),
      .change_irq_mask            (imask),
      .change_irq_status          (istat),
      .irq                        (irq)
   );

   pin_world u_world
   (
      .pin_out   (pin_out),
      .pin_oe    (pin_oe),
      .ext_en    (ext_en),
      .ext_level (ext_level),
      .pin_in    (pin_in)
   );

   // ==========================================================
   // Clock, hang guard, unfiltered-path watcher
   // ==========================================================
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Generous ceiling: the whole run needs about a hundred cycles
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         miscompares++;
         test_done();
      end
      if (periph_in[8] === 1'b0)
         lows <= lows + 1;
   end

   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One strobe cycle; returns at the negedge after it was taken
   task automatic wr(input int idx, input logic [31:0] d);
      @(posedge clock);
      stb[idx] <= 1'b1;
      wr_data  <= d;
      @(posedge clock);
      stb <= 12'h000;
      @(negedge clock);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      chk(ods, pio_pkg::OUT_DATA_RST);
      chk(mask, pio_pkg::SYNC_MASK_RST);
      chk(odr, pio_pkg::OPEN_DRAIN_RST);
      chk(filt, pio_pkg::FILTER_RST);
      chk(imask, pio_pkg::IRQ_MASK_RST);
      chk({31'h0, irq}, 32'h0000_0000);
   endtask

   task automatic t_output();
      wr(S_SET, 32'h0000_00F5);
      chk(ods, 32'h0000_00F5);
      chk(pin_out, 32'h0000_0000);
      cyc(1);
      chk(pin_out, 32'h0000_00F5);
      chk(pin_oe, 32'h0000_00FF);
      wr(S_CLR, 32'h0000_0005);
      chk(ods, 32'h0000_00F0);
      cyc(5);
      chk(pls, 32'hFFFF_FFF0);
   endtask

   task automatic t_sync();
      wr(S_MEN, 32'h0000_000F);
      wr(S_MDIS, 32'h0000_0003);
      chk(mask, 32'h0000_000C);
      wr(S_ODS, 32'h0000_00FF);
      chk(ods, 32'h0000_00FC);
      wr(S_ODS, 32'h0000_0000);
      chk(ods, 32'h0000_00F0);
      wr(S_MDIS, 32'hFFFF_FFFF);
      chk(mask, 32'h0000_0000);
   endtask

   task automatic t_drain();
      line_owned <= 32'hFFFF_FEFD;
      periph_oe  <= 32'h0000_0002;
      periph_out <= 32'h0000_0002;
      wr(S_ODEN, 32'h0000_0013);
      chk(odr, 32'h0000_0013);
      cyc(1);
      chk(pin_oe & 32'h0000_0013, 32'h0000_0001);
      chk(pin_out & 32'h0000_0013, 32'h0000_0000);
      wr(S_ODDIS, 32'hFFFF_FFFF);
      chk(odr, 32'h0000_0000);
      cyc(5);
   endtask

   task automatic t_irq();
      wr(S_IEN, 32'h0000_0300);
      wr(S_IDIS, 32'h0000_0200);
      chk(imask, 32'h0000_0100);
      wr(S_RD, 32'h0000_0000);
      ext_en    <= 32'h0000_0300;
      ext_level <= 32'h0000_0000;
      cyc(5);
      chk(pls & 32'h0000_0300, 32'h0000_0000);
      chk(istat, 32'h0000_0300);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(S_RD, 32'h0000_0000);
      chk(istat, 32'h0000_0000);
      cyc(1);
      chk({31'h0, irq}, 32'h0000_0000);
      ext_level <= 32'h0000_0200;
      cyc(5);
      chk(istat, 32'h0000_0200);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(S_RD, 32'h0000_0000);
   endtask

   task automatic t_gate();
      clock_on <= 1'b0;
      cyc(4);
      ext_level <= 32'h0000_0300;
      cyc(6);
      chk(pls & 32'h0000_0100, 32'h0000_0000);
      chk(istat, 32'h0000_0000);
      clock_on <= 1'b1;
      cyc(8);
      chk(pls & 32'h0000_0100, 32'h0000_0100);
      chk(istat, 32'h0000_0100);
      wr(S_RD, 32'h0000_0000);
   endtask

   task automatic t_filter();
      int lows0;
      wr(S_FEN, 32'h0000_0100);
      chk(filt, 32'h0000_0100);
      lows0 = lows;
      // Glitch of 6 ns straddling a rising edge
      #7 ext_level[8] = 1'b0;
      #6 ext_level[8] = 1'b1;
      cyc(6);
      chk(pls & 32'h0000_0100, 32'h0000_0100);
      chk(istat, 32'h0000_0000);
      chk(32'(lows - lows0), 32'h0000_0001);
      @(posedge clock);
      ext_level <= 32'h0000_0200;
      @(posedge clock);
      ext_level <= 32'h0000_0300;
      cyc(6);
      chk(istat, 32'h0000_0100);
      wr(S_RD, 32'h0000_0000);
      wr(S_FDIS, 32'hFFFF_FFFF);
      chk(filt, 32'h0000_0000);
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      rst_b         = 1'b0;
      clock_on      = 1'b0;
      wr_data       = 32'h0000_0000;
      stb           = 12'h000;
      line_owned    = 32'hFFFF_FFFF;
      line_drive_en = 32'h0000_00FF;
      periph_out    = 32'h0000_0000;
      periph_oe     = 32'h0000_0000;
      ext_en        = 32'h0000_0000;
      ext_level     = 32'h0000_0000;
      miscompares   = 0;
      checks_done   = 0;
      repeat (6) @(posedge clock);
      rst_b    <= 1'b1;
      clock_on <= 1'b1;
      cyc(4);
      t_reset();
      t_output();
      t_sync();
      t_drain();
      t_irq();
      t_gate();
      t_filter();
      test_done();
   end
endmodule
